// [data_image_test_mode_ctrl.sv]
// Island data image with panel blocks and test-mode output ownership
`timescale 1ns/1ps
module data_image_test_mode_ctrl
  import dimg_pkg::*;
#(
  parameter bit EXIT_BY_WRITE = 1'b1 // Variant with exit register
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic [1:0]  cfg_mode,
  input  wire logic [15:0] cfg_password,
  input  wire logic        rtp_configured,
  input  wire logic [9:0]  p2m_count,
  input  wire logic [9:0]  m2p_count,
  input  wire logic        cfg_load,
  input  wire logic        autoconfig,
  input  wire logic        reset_cmd,
  input  wire logic        tool_test_on,
  input  wire logic        tool_test_off,
  input  wire logic        hmi_req,
  input  wire logic        hmi_we,
  input  wire logic        hmi_single,
  input  wire logic [15:0] hmi_addr,
  input  wire logic [15:0] hmi_wdata,
  output logic             hmi_ack,
  output logic      [15:0] hmi_rdata,
  input  wire logic        fb_req,
  input  wire logic        fb_we,
  input  wire logic [15:0] fb_addr,
  input  wire logic [15:0] fb_wdata,
  output logic             fb_ack,
  output logic      [15:0] fb_rdata,
  input  wire logic        isl_we,
  input  wire logic [15:0] isl_addr,
  input  wire logic [15:0] isl_wdata,
  input  wire logic [11:0] out_idx,
  output logic      [15:0] out_data,
  input  wire logic [15:0] status_in,
  output logic             test_led,
  output logic             owner_tool
);

  // Reset release synchroniser
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // Image storage; memories carry no reset
  logic [15:0] out_img  [IMG_WORDS];  // Standard output image
  logic [15:0] in_img   [IMG_WORDS];  // Input and I/O status image
  logic [15:0] m2p_img  [HMI_WORDS];  // Master words, fieldbus order
  logic [15:0] p2m_img  [HMI_WORDS];  // Panel words, Modbus order
  logic [15:0] rtpq_img [RTPQ_WORDS]; // Parameter request
  logic [15:0] rtps_img [RTPS_WORDS]; // Parameter response

  test_state_t state_reg;    // Test mode state
  logic        boot_reg;     // First enabled cycle after reset
  logic        in_test;      // Outputs owned by panel or tool

  assign in_test = (state_reg != TM_OFF);

  // Fieldbus format is the 16-bit word with bytes swapped
  function automatic logic [15:0] swap(input logic [15:0] w);
    swap = {w[7:0], w[15:8]};
  endfunction

  // Range test on register numbers
  function automatic logic inr(input logic [15:0] a,
                               input logic [15:0] lo,
                               input logic [15:0] hi);
    inr = (a >= lo) && (a <= hi);
  endfunction

  // Offsets within each region
  logic [15:0] fb_off_out, fb_off_m2p, fb_off_q;
  logic [15:0] h_off_out, h_off_m2p, h_off_p2m, h_off_q;
  logic [15:0] i_off_in, i_off_s;
  assign fb_off_out = fb_addr - OUT_BASE;
  assign fb_off_m2p = fb_addr - M2P_BASE;
  assign fb_off_q   = fb_addr - RTPQ_BASE;
  assign h_off_out  = hmi_addr - OUT_BASE;
  assign h_off_m2p  = hmi_addr - M2P_BASE;
  assign h_off_p2m  = hmi_addr - P2M_BASE;
  assign h_off_q    = hmi_addr - RTPQ_BASE;
  assign i_off_in   = isl_addr - IN_BASE;
  assign i_off_s    = isl_addr - RTPS_BASE;

  // Panel blocks hold only the configured count of words
  logic fb_m2p_hit, h_m2p_hit, h_p2m_hit;
  assign fb_m2p_hit = inr(fb_addr, M2P_BASE, M2P_END)
                    && (fb_off_m2p < {6'h00, m2p_count});
  assign h_m2p_hit  = inr(hmi_addr, M2P_BASE, M2P_END)
                    && (h_off_m2p < {6'h00, m2p_count});
  assign h_p2m_hit  = inr(hmi_addr, P2M_BASE, P2M_END)
                    && (h_off_p2m < {6'h00, p2m_count});

  // Qualified write strobes
  logic fb_wr, h_wr;
  assign fb_wr = fb_req && fb_we;
  assign h_wr  = hmi_req && hmi_we;

  // Output image: master owns it outside test mode, panel inside
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      // Master write in test mode falls through, no error
      if (fb_wr && !in_test && inr(fb_addr, OUT_BASE, OUT_END)) begin
        out_img[fb_off_out[11:0]] <= fb_wdata;
      end else if (h_wr && in_test
                   && inr(hmi_addr, OUT_BASE, OUT_END)) begin
        out_img[h_off_out[11:0]] <= hmi_wdata;
      end
    end
  end

  // Master-to-panel block, with the same ownership rule as the outputs
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (fb_wr && !in_test && fb_m2p_hit) begin
        m2p_img[fb_off_m2p[8:0]] <= fb_wdata;
      end else if (h_wr && in_test && h_m2p_hit) begin
        // Tool owns it in test mode; store in fieldbus order
        m2p_img[h_off_m2p[8:0]] <= swap(hmi_wdata);
      end
    end
  end

  // Panel-to-master block, always writable from the panel
  always_ff @(posedge ref_clk) begin
    if (clk_en && h_wr && h_p2m_hit) begin
      p2m_img[h_off_p2m[8:0]] <= hmi_wdata;
    end
  end

  // Parameter request words, present only when configured
  always_ff @(posedge ref_clk) begin
    if (clk_en && rtp_configured) begin
      if (fb_wr && !in_test && inr(fb_addr, RTPQ_BASE, RTPQ_END)) begin
        rtpq_img[fb_off_q[2:0]] <= fb_wdata;
      end else if (h_wr && in_test
                   && inr(hmi_addr, RTPQ_BASE, RTPQ_END)) begin
        rtpq_img[h_off_q[2:0]] <= hmi_wdata;
      end
    end
  end

  // Island side fills input image and parameter response
  always_ff @(posedge ref_clk) begin
    if (clk_en && isl_we) begin
      if (inr(isl_addr, IN_BASE, IN_END)) begin
        in_img[i_off_in[11:0]] <= isl_wdata;
      end else if (rtp_configured
                   && inr(isl_addr, RTPS_BASE, RTPS_END)) begin
        rtps_img[i_off_s[1:0]] <= isl_wdata;
      end
    end
  end

  // Status word: test bit and owner bit forced by this block
  logic [15:0] status_word;
  always_comb begin
    status_word = status_in;
    status_word[STAT_TEST_BIT]  = in_test;
    status_word[STAT_OWNER_BIT] = in_test;
  end

  // Image read. The fieldbus sees panel words swapped into its
  // format, the panel sees master words swapped back to Modbus.
  // Parameter words sit between the I/O image and panel blocks.
  function automatic logic [15:0] rd_word(input logic [15:0] a,
                                          input logic from_fb);
    logic [15:0] o;
    o = a - OUT_BASE;
    rd_word = 16'h0000; // Unmapped and write-only read zero
    if (inr(a, OUT_BASE, OUT_END)) begin
      rd_word = out_img[o[11:0]];
    end else if (inr(a, M2P_BASE, M2P_END)) begin
      o = a - M2P_BASE;
      if (o < {6'h00, m2p_count}) begin
        rd_word = from_fb ? m2p_img[o[8:0]]
                          : swap(m2p_img[o[8:0]]);
      end
    end else if (rtp_configured && inr(a, RTPQ_BASE, RTPQ_END)) begin
      o = a - RTPQ_BASE;
      rd_word = rtpq_img[o[2:0]];
    end else if (rtp_configured && inr(a, RTPS_BASE, RTPS_END)) begin
      o = a - RTPS_BASE;
      rd_word = rtps_img[o[1:0]];
    end else if (a == STAT_ADDR) begin
      rd_word = status_word;
    end else if (inr(a, IN_BASE, IN_END)) begin
      o = a - IN_BASE;
      rd_word = in_img[o[11:0]];
    end else if (inr(a, P2M_BASE, P2M_END)) begin
      o = a - P2M_BASE;
      if (o < {6'h00, p2m_count}) begin
        rd_word = from_fb ? swap(p2m_img[o[8:0]])
                          : p2m_img[o[8:0]];
      end
    end
  endfunction

  // Panel answer one cycle after each request; any register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hmi_ack   <= 1'b0;
      hmi_rdata <= 16'h0000;
    end else if (clk_en) begin
      hmi_ack <= hmi_req;
      if (hmi_req && !hmi_we) begin
        hmi_rdata <= rd_word(hmi_addr, 1'b0);
      end
    end
  end

  // Fieldbus answer; reads keep working in test mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_ack   <= 1'b0;
      fb_rdata <= 16'h0000;
    end else if (clk_en) begin
      fb_ack <= fb_req;
      if (fb_req && !fb_we) begin
        fb_rdata <= rd_word(fb_addr, 1'b1);
      end
    end
  end

  // Output image toward the island modules
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= 16'h0000;
    end else if (clk_en) begin
      out_data <= out_img[out_idx];
    end
  end

  // Password events come only from the panel port; a fieldbus
  // write to these register numbers decodes to nothing.
  logic pw_valid, pw_match, pw_enter, pw_exit;
  assign pw_valid = (cfg_password != PW_NONE);
  assign pw_match = h_wr && hmi_single && pw_valid
                  && (hmi_wdata == cfg_password);
  assign pw_enter = pw_match && (hmi_addr == PW_ENTER);
  assign pw_exit  = pw_match && (hmi_addr == PW_EXIT)
                  && EXIT_BY_WRITE;

  // Setting after power-up or restart; unknown codes act temporary
  logic restart_pers;
  assign restart_pers = (cfg_mode == MODE_PERS);

  // Test mode controller. Only the listed events move it; the
  // panel link has no say, so a dropped Modbus session changes
  // nothing.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= TM_OFF;
      boot_reg  <= 1'b1;
    end else if (clk_en) begin
      boot_reg <= 1'b0;
      if (autoconfig) begin
        state_reg <= TM_OFF;
      end else if (cfg_load) begin
        // Download complete: persistent comes up at once
        state_reg <= restart_pers ? TM_PERS : TM_OFF;
      end else if (boot_reg || reset_cmd) begin
        // Power-up and reset command re-enter persistent only
        state_reg <= restart_pers ? TM_PERS : TM_OFF;
      end else begin
        case (state_reg)
          TM_OFF: begin
            if (tool_test_on && cfg_mode != MODE_PERS
                && cfg_mode != MODE_PASS) begin
              state_reg <= TM_TEMP;
            end else if (pw_enter && cfg_mode == MODE_PASS) begin
              state_reg <= TM_PASS;
            end
          end
          TM_TEMP: begin
            if (tool_test_off) begin
              state_reg <= TM_OFF;
            end
          end
          TM_PASS: begin
            if (pw_exit) begin
              state_reg <= TM_OFF;
            end
          end
          TM_PERS: begin
            state_reg <= TM_PERS;
          end
          default: begin
            state_reg <= TM_OFF;
          end
        endcase
      end
    end
  end

  // Indicator and owner flags from flip-flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      test_led   <= 1'b0;
      owner_tool <= 1'b0;
    end else if (clk_en) begin
      test_led   <= in_test;
      owner_tool <= in_test;
    end
  end

endmodule

// [dimg_pkg.sv]
// Constants and types for the data image and test-mode controller
package dimg_pkg;
  // Register numbers of the data image regions
  localparam logic [15:0] OUT_BASE   = 16'h9c41; // Output image start
  localparam logic [15:0] OUT_END    = 16'hac40; // Output image end
  localparam logic [15:0] M2P_BASE   = 16'hac41; // Master-to-panel start
  localparam logic [15:0] M2P_END    = 16'hae40; // Master-to-panel end
  localparam logic [15:0] PW_ENTER   = 16'hb040; // password_test_enter
  localparam logic [15:0] PW_EXIT    = 16'hb041; // password_test_exit
  localparam logic [15:0] RTPQ_BASE  = 16'hb04a; // Parameter request start
  localparam logic [15:0] RTPQ_END   = 16'hb04e; // Parameter request end
  localparam logic [15:0] RTPS_BASE  = 16'hb0f7; // Parameter response start
  localparam logic [15:0] RTPS_END   = 16'hb0fa; // Parameter response end
  localparam logic [15:0] STAT_ADDR  = 16'hb14f; // Module status word
  localparam logic [15:0] IN_BASE    = 16'hb150; // Input and I/O status start
  localparam logic [15:0] IN_END     = 16'hc14f; // Input and I/O status end
  localparam logic [15:0] P2M_BASE   = 16'hc150; // Panel-to-master start
  localparam logic [15:0] P2M_END    = 16'hc34f; // Panel-to-master end
  // Region sizes
  localparam int IMG_WORDS = 4096;  // Standard image depth
  localparam int HMI_WORDS = 512;   // Panel block depth
  localparam int RTPQ_WORDS = 5;    // Request words
  localparam int RTPS_WORDS = 4;    // Response words
  // Status word fields
  localparam int STAT_TEST_BIT  = 5;  // Test mode active
  localparam int STAT_OWNER_BIT = 15; // Output owner is the tool
  // Configured test mode setting encodings
  localparam logic [1:0] MODE_TEMP = 2'h0; // Default setting
  localparam logic [1:0] MODE_PERS = 2'h1;
  localparam logic [1:0] MODE_PASS = 2'h2;
  localparam logic [15:0] PW_NONE  = 16'h0000; // Not a legal password
  // Test mode controller states
  typedef enum logic [1:0] {
    TM_OFF,
    TM_TEMP,
    TM_PERS,
    TM_PASS
  } test_state_t;
endpackage

// [data_image_test_mode_ctrl_asserts.sv]
// Port-level checks for the data image and test-mode controller
`timescale 1ns/1ps
module data_image_test_mode_ctrl_asserts
  import dimg_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [1:0]  cfg_mode,
  input wire logic        cfg_load,
  input wire logic        autoconfig,
  input wire logic        reset_cmd,
  input wire logic        tool_test_off,
  input wire logic        hmi_req,
  input wire logic        hmi_we,
  input wire logic        hmi_single,
  input wire logic        hmi_ack,
  input wire logic [15:0] hmi_rdata,
  input wire logic        fb_req,
  input wire logic        fb_we,
  input wire logic        fb_ack,
  input wire logic        test_led,
  input wire logic        owner_tool
);
  // One domain; the raw reset mutes every check
  default clocking dflt @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // Each request answered exactly one edge later
  a_hmi_ack_next: assert property (hmi_req |=> hmi_ack)
    else $error("panel request not answered");
  a_fb_ack_next: assert property (fb_req |=> fb_ack)
    else $error("fieldbus request not answered");
  // No answer without its request
  a_hmi_ack_cause: assert property (hmi_ack |-> $past(hmi_req))
    else $error("panel answer without request");
  a_fb_ack_cause: assert property (fb_ack |-> $past(fb_req))
    else $error("fieldbus answer without request");
  // A write must not disturb the last read word
  a_write_keeps_rdata: assert property (
    hmi_req && hmi_we |=> $stable(hmi_rdata))
    else $error("panel read data moved on a write");
  a_owner_is_led: assert property (owner_tool == test_led)
    else $error("owner flag differs from test indicator");
  a_autocfg_ends_test: assert property (autoconfig |-> ##2 !test_led)
    else $error("test mode kept after autoconfiguration");
  // Load outcome depends only on the stored setting
  a_load_sets_mode: assert property (
    cfg_load && !autoconfig |-> ##2 (test_led == (cfg_mode == MODE_PERS)))
    else $error("wrong test state after load");
  a_deselect_ends_temp: assert property (
    tool_test_off && cfg_mode == MODE_TEMP |-> ##2 !test_led)
    else $error("temporary test mode kept after deselect");
  a_reset_cmd_mode: assert property (
    reset_cmd && !cfg_load && !autoconfig
    |-> ##2 (test_led == (cfg_mode == MODE_PERS)))
    else $error("wrong test state after reset command");
  // Main scenarios reached
  c_test_on: cover property ($rose(test_led));
  c_fb_write_in_test: cover property (fb_req && fb_we && test_led);
  c_single_write: cover property (hmi_req && hmi_we && hmi_single);
endmodule

bind data_image_test_mode_ctrl data_image_test_mode_ctrl_asserts i_asserts (.*);

// [master_panel_model.sv]
// Behavioural fieldbus master and panel on the two register ports
`timescale 1ns/1ps
module master_panel_model (
  input  wire logic        ref_clk,
  input  wire logic        hmi_ack,
  input  wire logic [15:0] hmi_rdata,
  input  wire logic        fb_ack,
  input  wire logic [15:0] fb_rdata,
  output logic             hmi_req,
  output logic             hmi_we,
  output logic             hmi_single,
  output logic      [15:0] hmi_addr,
  output logic      [15:0] hmi_wdata,
  output logic             fb_req,
  output logic             fb_we,
  output logic      [15:0] fb_addr,
  output logic      [15:0] fb_wdata
);
  // Idle at time zero
  initial begin
    {hmi_req, hmi_we, hmi_single, fb_req, fb_we} = 5'h00;
    {hmi_addr, hmi_wdata, fb_addr, fb_wdata} = 64'h0;
  end

  // One transfer; gap idles first so the master can also be slow
  task automatic xfer(input bit fb, input bit we, input bit sgl,
                      input logic [15:0] a, input logic [15:0] d,
                      input int gap, output logic [15:0] rd,
                      output bit ok);
    ok = 1'b0;
    rd = 16'h0000;
    repeat (gap + 1) @(posedge ref_clk);
    if (fb) begin
      {fb_req, fb_we, fb_addr, fb_wdata} <= {1'b1, we, a, d};
    end else begin
      {hmi_req, hmi_we, hmi_single} <= {1'b1, we, sgl};
      {hmi_addr, hmi_wdata} <= {a, d};
    end
    @(posedge ref_clk);
    // Released lines show the inverse so stale values never match
    if (fb) begin
      {fb_req, fb_addr, fb_wdata} <= {1'b0, ~a, ~d};
    end else begin
      {hmi_req, hmi_addr, hmi_wdata} <= {1'b0, ~a, ~d};
    end
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge ref_clk);
      ok = fb ? (fb_ack === 1'b1) : (hmi_ack === 1'b1);
      rd = fb ? fb_rdata : hmi_rdata;
    end
  endtask
endmodule

// [data_image_test_mode_ctrl_test.sv]
// Self-checking bench for the data image and test-mode controller
`timescale 1ns/1ps
module data_image_test_mode_ctrl_test
  import dimg_pkg::*;
;
  logic        ref_clk, rst_b, rtp_configured, isl_we, ok, clk_en;
  logic        cfg_load, autoconfig, reset_cmd, tool_test_on;
  logic        tool_test_off, test_led, owner_tool;
  logic        hmi_req, hmi_we, hmi_single, hmi_ack;
  logic        fb_req, fb_we, fb_ack;
  logic [1:0]  cfg_mode;
  logic [9:0]  p2m_count, m2p_count;
  logic [11:0] out_idx;
  logic [15:0] cfg_password, isl_addr, isl_wdata, status_in, out_data;
  logic [15:0] hmi_addr, hmi_wdata, hmi_rdata, fb_addr, fb_wdata;
  logic [15:0] fb_rdata, rd, k, v;
  logic [31:0] seed;
  int          failures, compares;

  // Enable is driven so that one scenario can freeze the block
  data_image_test_mode_ctrl i_data_image_test_mode_ctrl (.*);
  master_panel_model i_master_panel_model (.*);

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Repeatable xorshift source
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  // Fieldbus format is a byte swap
  function automatic logic [15:0] swp(input logic [15:0] w);
    return {w[7:0], w[15:8]};
  endfunction

  task automatic print_verdict();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check_word(input string what, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  // One access; a missing answer ends the run
  task automatic acc(input bit fb, we, sgl, input logic [15:0] a, d);
    i_master_panel_model.xfer(fb, we, sgl, a, d, xs() % 3, rd, ok);
    if (!ok) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic rdchk(input bit fb, input logic [15:0] a, e);
    acc(fb, 1'b0, 1'b0, a, 16'h0000);
    check_word("read", e, rd);
  endtask

  // Event pulse order: autoconfig, load, reset, on, off
  task automatic ev(input logic [4:0] p, input logic led);
    @(posedge ref_clk);
    {autoconfig, cfg_load, reset_cmd, tool_test_on, tool_test_off} <= p;
    @(posedge ref_clk);
    {autoconfig, cfg_load, reset_cmd, tool_test_on, tool_test_off} <= 5'h00;
    repeat (2) @(posedge ref_clk);
    check_word("led", {15'h0000, led}, {15'h0000, test_led});
    check_word("owner", {15'h0000, led}, {15'h0000, owner_tool});
  endtask

  task automatic out_chk(input logic [15:0] e);
    repeat (2) @(posedge ref_clk);
    check_word("out", e, out_data);
  endtask

  initial begin
    seed = 32'h0000_0011;
    rst_b = 1'b0;
    clk_en = 1'b1;
    {autoconfig, cfg_load, reset_cmd, tool_test_on, tool_test_off} = 5'h00;
    {cfg_mode, rtp_configured, isl_we} = {MODE_TEMP, 2'h2};
    {cfg_password, isl_addr, isl_wdata} = {16'hffff, IN_BASE, 16'h0000};
    {p2m_count, m2p_count, out_idx} = {10'h003, 10'h200, 12'h000};
    status_in = xs();
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdchk(1'b1, STAT_ADDR, status_in & 16'h7fdf);
    // Master updates, last one at the top of the block
    for (int i = 0; i < 4; i++) begin
      k = (i == 3) ? 16'h01ff : xs() % 16'h0200;
      v = xs();
      acc(1'b1, 1'b1, 1'b0, OUT_BASE + k, v);
      acc(1'b1, 1'b1, 1'b0, M2P_BASE + k, v);
      out_idx <= k[11:0];
      out_chk(v);
      rdchk(1'b0, M2P_BASE + k, swp(v));
      isl_we <= 1'b1;
      {isl_addr, isl_wdata} <= {IN_BASE + k, ~v};
      @(posedge ref_clk);
      isl_we <= 1'b0;
      rdchk(1'b0, IN_BASE + k, ~v);
      acc(1'b0, 1'b1, 1'b0, P2M_BASE + i, v);
      rdchk(1'b1, P2M_BASE + i, (i < 3) ? swp(v) : 16'h0000);
    end
    ev(5'h02, 1'b1);
    rdchk(1'b1, STAT_ADDR, status_in | 16'h8020);
    acc(1'b1, 1'b1, 1'b0, OUT_BASE + k, ~v);
    out_chk(v);
    acc(1'b0, 1'b1, 1'b0, OUT_BASE + k, ~v);
    out_chk(~v);
    acc(1'b0, 1'b1, 1'b0, RTPQ_BASE, v);
    acc(1'b1, 1'b1, 1'b0, RTPQ_BASE, ~v);
    rdchk(1'b0, RTPQ_BASE, v);
    ev(5'h01, 1'b0);
    rtp_configured <= 1'b0;
    rdchk(1'b0, RTPQ_BASE, 16'h0000);
    rtp_configured <= 1'b1;
    cfg_mode <= MODE_PASS;
    ev(5'h08, 1'b0);
    // Fieldbus entry, multi-register write, wrong password
    for (int i = 0; i < 3; i++) begin
      acc(i == 0, 1'b1, i != 1, PW_ENTER, (i == 2) ? 16'hfffe : 16'hffff);
      ev(5'h00, 1'b0);
    end
    acc(1'b0, 1'b1, 1'b1, PW_ENTER, 16'hffff);
    ev(5'h00, 1'b1);
    rdchk(1'b0, PW_ENTER, 16'h0000);
    acc(1'b0, 1'b1, 1'b1, PW_EXIT, 16'hffff);
    ev(5'h00, 1'b0);
    acc(1'b0, 1'b1, 1'b1, PW_ENTER, 16'hffff);
    ev(5'h04, 1'b0);
    cfg_mode <= MODE_PERS;
    ev(5'h08, 1'b1);
    ev(5'h01, 1'b1);
    ev(5'h04, 1'b1);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ev(5'h00, 1'b1);
    ev(5'h10, 1'b0);
    cfg_mode <= 2'h3;
    // Frozen block must ignore a tool entry pulse
    clk_en <= 1'b0;
    ev(5'h02, 1'b0);
    clk_en <= 1'b1;
    ev(5'h00, 1'b0);
    ev(5'h02, 1'b1);
    ev(5'h10, 1'b0);
    print_verdict();
  end
endmodule
